// File: rtl/gpe_port.sv
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Eight independent pin bits, bit 7 down to 0, in every register.
// R2: Data reads return the sampled pin level for input pins.
// R3: Data reads return the last written value for output pins.
// R4: Data writes store all eight bits, even for input pins.
// R5: Output pins are driven with their stored data bit.
// R6: Reset clears data to zero; pins stay undriven so zeros never appear.
// R7: After reset all pins are inputs, pull-ups off, all control bits zero.
// R8: Direction bit clear disables the driver; reads return pin level.
// R9: Direction bit set enables the driver; reads return stored bit.
// R10: Pull-up enable bit one turns pull-up on, zero turns it off.
// R11: Output pins keep their pull-up off whatever the enable bit says.
// R12: Slew enable bit one enables slew limiting, zero disables it.
// R13: Slew enable bit has no effect on input pins.
// R14: Drive bit one selects high drive, zero selects low drive.
// R15: Direction, pull-up, slew and drive registers read back last written value.
module gpe_port (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [gpe_pkg::ADR_W-1:0]     wb_adr_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [gpe_pkg::PORT_W-1:0]    pin_in,
  output logic      [gpe_pkg::PORT_W-1:0]    pin_out,
  output logic      [gpe_pkg::PORT_W-1:0]    pin_oe_n,
  output logic      [gpe_pkg::PORT_W-1:0]    pin_pullup_en,
  output logic      [gpe_pkg::PORT_W-1:0]    pin_slew_en,
  output logic      [gpe_pkg::PORT_W-1:0]    pin_drive_hi
);

  gpe_pkg::gpe_state_s s_q;
  gpe_pkg::gpe_state_s s_d;

  logic                          req;
  logic                          wr;
  logic [gpe_pkg::REG_N-1:0]     hit;
  logic [gpe_pkg::PORT_W-1:0]    data_rd;
  logic [gpe_pkg::PORT_W-1:0]    nxt_out;
  logic [gpe_pkg::PORT_W-1:0]    nxt_oe_n;
  logic [gpe_pkg::PORT_W-1:0]    nxt_pullup;
  logic [gpe_pkg::PORT_W-1:0]    nxt_slew;
  logic [gpe_pkg::PORT_W-1:0]    nxt_drive;

  gpe_wb_decode u_decode (
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_sel_i (wb_sel_i),
    .wb_adr_i (wb_adr_i),
    .ack_q    (s_q.ack),
    .req      (req),
    .wr       (wr),
    .hit      (hit)
  );

  // Pad controls follow the next register values so they change with the write.
  for (genvar i = 0; i < gpe_pkg::PORT_W; i++)
  begin : g_pad
    gpe_pad_bit u_pad (
      .dir      (s_d.pin_direction[i]),
      .data     (s_d.pin_data[i]),
      .pe       (s_d.pullup_enable[i]),
      .se       (s_d.slew_limit_enable[i]),
      .ds       (s_d.drive_strength_select[i]),
      .out      (nxt_out[i]),
      .oe_n     (nxt_oe_n[i]),
      .pu_en    (nxt_pullup[i]),
      .slew     (nxt_slew[i]),
      .drive_hi (nxt_drive[i])
    );
  end

  // Input pins show their level, output pins show the stored bit.
  assign data_rd = (s_q.pin_direction & s_q.pin_data)
                 | (~s_q.pin_direction & pin_in);     // R2 R3 R8 R9

  always_comb
  begin
    s_d     = s_q;
    s_d.ack = req;
    if (wr && hit[gpe_pkg::HIT_PIN_DATA])
    begin
      s_d.pin_data = wb_dat_i[gpe_pkg::PORT_W-1:0];   // R4 R1
    end
    if (wr && hit[gpe_pkg::HIT_PIN_DIR])
    begin
      s_d.pin_direction = wb_dat_i[gpe_pkg::PORT_W-1:0];
    end
    if (wr && hit[gpe_pkg::HIT_PULLUP])
    begin
      s_d.pullup_enable = wb_dat_i[gpe_pkg::PORT_W-1:0];
    end
    if (wr && hit[gpe_pkg::HIT_SLEW])
    begin
      s_d.slew_limit_enable = wb_dat_i[gpe_pkg::PORT_W-1:0];
    end
    if (wr && hit[gpe_pkg::HIT_DRIVE_SEL])
    begin
      s_d.drive_strength_select = wb_dat_i[gpe_pkg::PORT_W-1:0];
    end
    s_d.rdat = gpe_pkg::RST_BYTE;
    if (req && !wb_we_i)
    begin
      s_d.rdat = ({gpe_pkg::PORT_W{hit[gpe_pkg::HIT_PIN_DATA]}} & data_rd)
               | ({gpe_pkg::PORT_W{hit[gpe_pkg::HIT_PIN_DIR]}} & s_q.pin_direction)
               | ({gpe_pkg::PORT_W{hit[gpe_pkg::HIT_PULLUP]}} & s_q.pullup_enable)
               | ({gpe_pkg::PORT_W{hit[gpe_pkg::HIT_SLEW]}} & s_q.slew_limit_enable)
               | ({gpe_pkg::PORT_W{hit[gpe_pkg::HIT_DRIVE_SEL]}}
                  & s_q.drive_strength_select);       // R15
    end
    s_d.pad_out      = nxt_out;                       // R5
    s_d.pad_oe_n     = nxt_oe_n;                      // R8 R9
    s_d.pad_pullup   = nxt_pullup;                    // R10 R11
    s_d.pad_slew     = nxt_slew;                      // R12 R13
    s_d.pad_drive_hi = nxt_drive;                     // R14
  end

  // Reset leaves every pin an undriven input with all pad options off.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q                       <= '0;
      s_q.pin_data              <= gpe_pkg::RST_BYTE;  // R6
      s_q.pin_direction         <= gpe_pkg::RST_BYTE;  // R7
      s_q.pullup_enable         <= gpe_pkg::RST_BYTE;  // R7
      s_q.slew_limit_enable     <= gpe_pkg::RST_BYTE;  // R7
      s_q.drive_strength_select <= gpe_pkg::RST_BYTE;  // R7
      s_q.pad_oe_n              <= {gpe_pkg::PORT_W{1'b1}};  // R6 R7
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o      = s_q.ack;
  assign wb_dat_o      = {gpe_pkg::RD_PAD, s_q.rdat};
  assign pin_out       = s_q.pad_out;
  assign pin_oe_n      = s_q.pad_oe_n;
  assign pin_pullup_en = s_q.pad_pullup;
  assign pin_slew_en   = s_q.pad_slew;
  assign pin_drive_hi  = s_q.pad_drive_hi;

  // Assertions and covers.
  logic rd_data_q;
  logic rd_dir_q;
  logic rd_pe_q;
  logic rd_se_q;
  logic rd_ds_q;

  assign rd_data_q = wb_ack_o && !wb_we_i && hit[gpe_pkg::HIT_PIN_DATA];
  assign rd_dir_q  = wb_ack_o && !wb_we_i && hit[gpe_pkg::HIT_PIN_DIR];
  assign rd_pe_q   = wb_ack_o && !wb_we_i && hit[gpe_pkg::HIT_PULLUP];
  assign rd_se_q   = wb_ack_o && !wb_we_i && hit[gpe_pkg::HIT_SLEW];
  assign rd_ds_q   = wb_ack_o && !wb_we_i && hit[gpe_pkg::HIT_DRIVE_SEL];

  a_data_write_all: assert property ( // R4
    @(posedge clk) disable iff (!resetn)
    (wr && hit[gpe_pkg::HIT_PIN_DATA])
    |=> (s_q.pin_data == $past(wb_dat_i[7:0])) ##1 (pin_out == $past(s_q.pin_data)))
    else $error("Pin data write not stored.");

  a_data_read_mix: assert property ( // R2
    @(posedge clk) disable iff (!resetn)
    rd_data_q |-> (wb_dat_o[7:0] == (($past(s_q.pin_direction) & $past(s_q.pin_data))
                  | (~$past(s_q.pin_direction) & $past(pin_in)))))
    else $error("Pin data read mixes levels wrongly.");

  a_out_read_stored: assert property ( // R3
    @(posedge clk) disable iff (!resetn)
    (req && !wb_we_i && hit[gpe_pkg::HIT_PIN_DATA] && (s_q.pin_direction == 8'hFF))
    |=> wb_ack_o && (wb_dat_o[7:0] == $past(s_q.pin_data)))
    else $error("Output pins do not read back stored data.");

  a_drive_matches: assert property ( // R5
    @(posedge clk) disable iff (!resetn)
    ((~pin_oe_n & (pin_out ^ s_q.pin_data)) == 8'h00))
    else $error("Driven pin differs from stored bit.");

  a_dir_write_oe: assert property ( // R8
    @(posedge clk) disable iff (!resetn)
    (wr && hit[gpe_pkg::HIT_PIN_DIR])
    |=> (pin_oe_n == ~$past(wb_dat_i[7:0])))
    else $error("Driver enables do not follow direction write.");

  a_oe_tracks_dir: assert property ( // R9
    @(posedge clk) disable iff (!resetn)
    (pin_oe_n == ~s_q.pin_direction))
    else $error("Driver enable disagrees with direction.");

  a_pullup_gated: assert property ( // R11
    @(posedge clk) disable iff (!resetn)
    ((pin_pullup_en & ~pin_oe_n) == 8'h00))
    else $error("Pull-up on while pin drives.");

  a_pullup_follow: assert property ( // R10
    @(posedge clk) disable iff (!resetn)
    (wr && hit[gpe_pkg::HIT_PULLUP])
    |=> (pin_pullup_en == ($past(wb_dat_i[7:0]) & ~s_q.pin_direction)))
    else $error("Pull-up does not follow its enable.");

  a_slew_input_off: assert property ( // R13
    @(posedge clk) disable iff (!resetn)
    ((pin_slew_en & pin_oe_n) == 8'h00))
    else $error("Slew limiting active on an input.");

  a_slew_follow: assert property ( // R12
    @(posedge clk) disable iff (!resetn)
    (pin_slew_en == (s_q.slew_limit_enable & s_q.pin_direction)))
    else $error("Slew output disagrees with its enable.");

  a_drive_select: assert property ( // R14
    @(posedge clk) disable iff (!resetn)
    (wr && hit[gpe_pkg::HIT_DRIVE_SEL])
    |=> (pin_drive_hi == $past(wb_dat_i[7:0])))
    else $error("Drive select not applied.");

  a_dir_readback: assert property ( // R15
    @(posedge clk) disable iff (!resetn)
    rd_dir_q |-> (wb_dat_o[7:0] == $past(s_q.pin_direction)))
    else $error("Direction register read mismatch.");

  a_pe_readback: assert property ( // R15
    @(posedge clk) disable iff (!resetn)
    rd_pe_q |-> (wb_dat_o[7:0] == $past(s_q.pullup_enable)))
    else $error("Pull-up register read mismatch.");

  a_se_readback: assert property ( // R15
    @(posedge clk) disable iff (!resetn)
    rd_se_q |-> (wb_dat_o[7:0] == $past(s_q.slew_limit_enable)))
    else $error("Slew register read mismatch.");

  a_ds_readback: assert property ( // R15
    @(posedge clk) disable iff (!resetn)
    rd_ds_q |-> (wb_dat_o[7:0] == $past(s_q.drive_strength_select)))
    else $error("Drive register read mismatch.");

  a_ack_single: assert property ( // Wishbone access
    @(posedge clk) disable iff (!resetn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Acknowledge is not a single cycle.");

  a_upper_zero: assert property ( // R1
    @(posedge clk) disable iff (!resetn)
    (wb_dat_o[31:8] == 24'h000000))
    else $error("Upper read data bits not zero.");

  c_input_read: cover property (
    @(posedge clk) disable iff (!resetn)
    rd_data_q && (s_q.pin_direction == 8'h00));

  c_output_drive: cover property (
    @(posedge clk) disable iff (!resetn)
    (pin_oe_n == 8'h00) && (pin_out != 8'h00));

  c_pullup_masked: cover property (
    @(posedge clk) disable iff (!resetn)
    (s_q.pullup_enable != 8'h00) && (pin_pullup_en == 8'h00));

  c_mixed_dir: cover property (
    @(posedge clk) disable iff (!resetn)
    rd_data_q && (s_q.pin_direction == 8'h0F));

endmodule : gpe_port

// File: pkg/gpe_pkg.sv
package gpe_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned REG_N  = 5;

  localparam logic [ADR_W-1:0] OFS_PIN_DATA  = 8'h00;
  localparam logic [ADR_W-1:0] OFS_PIN_DIR   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_PULLUP    = 8'h08;
  localparam logic [ADR_W-1:0] OFS_SLEW      = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_DRIVE_SEL = 8'h10;

  localparam int unsigned HIT_PIN_DATA  = 0;
  localparam int unsigned HIT_PIN_DIR   = 1;
  localparam int unsigned HIT_PULLUP    = 2;
  localparam int unsigned HIT_SLEW      = 3;
  localparam int unsigned HIT_DRIVE_SEL = 4;

  localparam logic [PORT_W-1:0] RST_BYTE = 8'h00;
  localparam logic [23:0]       RD_PAD   = 24'h000000;

  typedef struct packed {
    logic [PORT_W-1:0] pin_data;
    logic [PORT_W-1:0] pin_direction;
    logic [PORT_W-1:0] pullup_enable;
    logic [PORT_W-1:0] slew_limit_enable;
    logic [PORT_W-1:0] drive_strength_select;
    logic              ack;
    logic [PORT_W-1:0] rdat;
    logic [PORT_W-1:0] pad_out;
    logic [PORT_W-1:0] pad_oe_n;
    logic [PORT_W-1:0] pad_pullup;
    logic [PORT_W-1:0] pad_slew;
    logic [PORT_W-1:0] pad_drive_hi;
  } gpe_state_s;

endpackage : gpe_pkg

// File: rtl/gpe_pad_bit.sv
`timescale 1ns/1ps
module gpe_pad_bit (
  input  wire logic dir,
  input  wire logic data,
  input  wire logic pe,
  input  wire logic se,
  input  wire logic ds,
  output logic      out,
  output logic      oe_n,
  output logic      pu_en,
  output logic      slew,
  output logic      drive_hi
);

  // Drives the stored bit whenever the pin is an output.
  assign out      = data;              // R5
  assign oe_n     = ~dir;              // R8 R9
  assign pu_en    = pe & ~dir;         // R10 R11
  assign slew     = se & dir;          // R12 R13
  assign drive_hi = ds;                // R14

endmodule : gpe_pad_bit

// File: rtl/gpe_wb_decode.sv
`timescale 1ns/1ps
module gpe_wb_decode (
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [gpe_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic                       ack_q,
  output logic                            req,
  output logic                            wr,
  output logic [gpe_pkg::REG_N-1:0]       hit
);

  logic [gpe_pkg::ADR_W-1:0] word_adr;

  // Low address bits are ignored so each register takes one aligned word.
  assign word_adr = {wb_adr_i[gpe_pkg::ADR_W-1:2], 2'h0};
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i & wb_sel_i[0];

  assign hit[gpe_pkg::HIT_PIN_DATA]  = (word_adr == gpe_pkg::OFS_PIN_DATA);
  assign hit[gpe_pkg::HIT_PIN_DIR]   = (word_adr == gpe_pkg::OFS_PIN_DIR);
  assign hit[gpe_pkg::HIT_PULLUP]    = (word_adr == gpe_pkg::OFS_PULLUP);
  assign hit[gpe_pkg::HIT_SLEW]      = (word_adr == gpe_pkg::OFS_SLEW);
  assign hit[gpe_pkg::HIT_DRIVE_SEL] = (word_adr == gpe_pkg::OFS_DRIVE_SEL);

endmodule : gpe_wb_decode

// File: dv/gpe_pin_model.sv
`timescale 1ns/1ps
// Models the eight package pins and whatever is wired to them outside the chip.
module gpe_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] float_q = 8'h00;

  // An undriven pin with no pull-up shows a level that changes every cycle.
  always @(posedge clk)
  begin
    float_q <= ~float_q;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      // An enabled outside source overpowers the pad, so reads can tell pin from register.
      if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_oe_n[i] == 1'b0)
        pin_in[i] = pin_out[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_q[i];
    end
  end
endmodule : gpe_pin_model

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  oe_n;
  logic [7:0]  pu;
  logic [7:0]  slew;
  logic [7:0]  drv;
  logic [7:0]  ext_en;
  logic [7:0]  ext_val;
  logic [31:0] rd;
  logic [7:0]  snap;
  logic [7:0]  mdl[5];
  logic [7:0]  ofs[6];
  int          fails = 0;
  int          tests_run = 0;
  int          cyc_n = 0;
  int          k;

  gpe_port gpe_port_inst (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_pullup_en(pu), .pin_slew_en(slew), .pin_drive_hi(drv));

  gpe_pin_model gpe_pin_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_pullup_en(pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task results;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      fails++;
      results();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; low address bits and upper data lanes are randomised.
  task xfer(input logic w, input int idx, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= ofs[idx] | 8'($urandom % 4);
    wdat <= {24'($urandom), d};
    sel  <= s;
    @(negedge clk);
    snap = pin_in;
    @(posedge clk);
    while (ack !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    chk(32'(ack), 32'h1);
    if (w && s[0] && idx < 5)
      mdl[idx] = d;
  endtask : xfer

  function automatic logic [31:0] exp_rd(input int idx);
    if (idx == 0)
      return {24'h000000, (mdl[1] & mdl[0]) | (~mdl[1] & snap)};
    return (idx < 5) ? 32'(mdl[idx]) : 32'h0;
  endfunction : exp_rd

  task pads;
    chk(32'(pin_out), 32'(mdl[0]));
    chk(32'(oe_n), {24'h000000, ~mdl[1]});
    chk(32'(pu), {24'h000000, mdl[2] & ~mdl[1]});
    chk(32'(slew), 32'(mdl[3] & mdl[1]));
    chk(32'(drv), 32'(mdl[4]));
  endtask : pads

  initial
  begin
    ofs = '{gpe_pkg::OFS_PIN_DATA, gpe_pkg::OFS_PIN_DIR, gpe_pkg::OFS_PULLUP,
            gpe_pkg::OFS_SLEW, gpe_pkg::OFS_DRIVE_SEL, 8'h14};
    mdl = '{default: 8'h00};
    resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    ext_en = 8'h00;
    ext_val = 8'h00;
    void'($urandom(21752));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    pads();
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, i, 8'h00, 4'hF);
      chk(rd, exp_rd(i));
    end
    for (int i = 0; i < 80; i++)
    begin
      @(posedge clk);
      ext_en  <= 8'($urandom);
      ext_val <= 8'($urandom);
      xfer(1'b1, int'($urandom % 6), 8'($urandom), ($urandom % 5 == 0) ? 4'hE : 4'hF);
      pads();
      k = int'($urandom % 6);
      xfer(1'b0, k, 8'h00, 4'($urandom));
      chk(rd, exp_rd(k));
    end
    // Outside sources press on every pin while the port drives some or all of them.
    @(posedge clk);
    ext_en  <= 8'hFF;
    ext_val <= 8'($urandom);
    xfer(1'b1, 1, 8'hFF, 4'hF);
    xfer(1'b1, 0, 8'($urandom), 4'hF);
    pads();
    xfer(1'b0, 0, 8'h00, 4'hF);
    chk(rd, exp_rd(0));
    xfer(1'b1, 1, 8'h0F, 4'hF);
    pads();
    xfer(1'b0, 0, 8'h00, 4'hF);
    chk(rd, exp_rd(0));
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    mdl = '{default: 8'h00};
    pads();
    xfer(1'b0, 1, 8'h00, 4'hF);
    chk(rd, exp_rd(1));
    results();
  end
endmodule : testbench
